// file: rtl/bcs_sequencer.sv
// breaker control sequencer with apb register access
`timescale 1ns/1ps
module bcs_sequencer #(
  parameter int TICK_CYCLES = bcs_pkg::TICK_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        remote_trip,
  input  wire logic        remote_close,
  input  wire logic        opto_trip,
  input  wire logic        opto_close,
  input  wire logic        contact_follows_breaker,
  input  wire logic        contact_opposes_breaker,
  input  wire logic        protection_trip,
  input  wire logic        sync_ok,
  input  wire logic        breaker_ready,
  output logic             trip_out,
  output logic             close_out,
  output logic             open_failure_alarm,
  output logic             shut_failure_alarm,
  output logic             sync_alarm,
  output logic             ready_alarm,
  output logic             lockout,
  output logic             lockout_clear,
  output logic             reclose_block_after_manual,
  output logic             control_inhibit,
  output logic [1:0]       display_mode
);
  localparam int W = bcs_pkg::CNT_W;

  if (TICK_CYCLES < 1) begin : g_tick_check
    $error("TICK_CYCLES must be at least 1");
  end

  function automatic logic [W-1:0] bump(input logic [W-1:0] c, input logic t);
    bump = (t && c != {W{1'b1}}) ? c + W'(1) : c;
  endfunction : bump

  // apb slave, zero wait states
  logic          wr_en;
  logic          rd_hit;
  logic [7:0]    config_reg;
  logic [W-1:0]  trip_time;
  logic [W-1:0]  close_time;
  logic [W-1:0]  close_delay;
  logic [W-1:0]  ready_win;
  logic [W-1:0]  sync_win;
  logic [W-1:0]  ar_block;
  logic [10:0]   cmd;

  assign wr_en = psel && penable && pwrite;
  assign pready = 1'b1;
  always_comb begin
    unique case (paddr)
      bcs_pkg::ADDR_CONFIG, bcs_pkg::ADDR_TRIP_TIME, bcs_pkg::ADDR_CLOSE_TIME,
      bcs_pkg::ADDR_CLOSE_DELAY, bcs_pkg::ADDR_READY_WIN, bcs_pkg::ADDR_SYNC_WIN,
      bcs_pkg::ADDR_AR_BLOCK, bcs_pkg::ADDR_COMMAND, bcs_pkg::ADDR_STATUS: rd_hit = 1'b1;
      default: rd_hit = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !rd_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_reg  <= bcs_pkg::CONFIG_RESET;
      trip_time   <= bcs_pkg::TRIP_TIME_RESET;
      close_time  <= bcs_pkg::CLOSE_TIME_RESET;
      close_delay <= bcs_pkg::CLOSE_DELAY_RESET;
      ready_win   <= bcs_pkg::READY_WIN_RESET;
      sync_win    <= bcs_pkg::SYNC_WIN_RESET;
      ar_block    <= bcs_pkg::AR_BLOCK_RESET;
    end else if (wr_en) begin
      unique case (paddr)
        bcs_pkg::ADDR_CONFIG:      config_reg  <= pwdata[7:0];
        bcs_pkg::ADDR_TRIP_TIME:   trip_time   <= pwdata[W-1:0];
        bcs_pkg::ADDR_CLOSE_TIME:  close_time  <= pwdata[W-1:0];
        bcs_pkg::ADDR_CLOSE_DELAY: close_delay <= pwdata[W-1:0];
        bcs_pkg::ADDR_READY_WIN:   ready_win   <= pwdata[W-1:0];
        bcs_pkg::ADDR_SYNC_WIN:    sync_win    <= pwdata[W-1:0];
        bcs_pkg::ADDR_AR_BLOCK:    ar_block    <= pwdata[W-1:0];
        default: ;
      endcase
    end
  end

  // command strobes last one cycle
  assign cmd = (wr_en && paddr == bcs_pkg::ADDR_COMMAND) ? pwdata[10:0] : 11'h000;

  // millisecond tick
  logic [31:0] tick_div;
  logic        tick;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_div <= 32'h0;
      tick     <= 1'b0;
    end else if (tick_div >= 32'(TICK_CYCLES - 1)) begin
      tick_div <= 32'h0;
      tick     <= 1'b1;
    end else begin
      tick_div <= tick_div + 32'h1;
      tick     <= 1'b0;
    end
  end

  // breaker position
  bcs_pkg::bcs_pos_e pos_src;
  logic [2:0]        src_sel;
  logic              closed;
  logic              pos_valid;
  assign pos_src = bcs_pkg::bcs_pos_e'(config_reg[bcs_pkg::CF_POS_LSB +: 2]);
  assign src_sel = config_reg[bcs_pkg::CF_SRC_LSB +: 3];
  always_comb begin
    unique case (pos_src)
      bcs_pkg::BCS_POS_NONE: begin
        closed    = 1'b0;
        pos_valid = 1'b0;
      end
      bcs_pkg::BCS_POS_FOLLOWS: begin
        closed    = contact_follows_breaker;
        pos_valid = 1'b1;
      end
      bcs_pkg::BCS_POS_OPPOSES: begin
        closed    = !contact_opposes_breaker;
        pos_valid = 1'b1;
      end
      bcs_pkg::BCS_POS_BOTH: begin
        closed    = contact_follows_breaker;
        pos_valid = contact_follows_breaker != contact_opposes_breaker;
      end
    endcase
  end
  assign control_inhibit = (pos_src == bcs_pkg::BCS_POS_NONE);

  // shortcut key menu
  bcs_pkg::bcs_key_e key_state;
  bcs_pkg::bcs_seq_e seq;
  logic              key_is_close;
  logic [W-1:0]      key_idle;
  logic [W-1:0]      holdoff;
  logic              key_any;
  logic              holdoff_on;
  logic              key_trip_go;
  logic              key_close_go;
  assign key_any = |cmd[bcs_pkg::CMD_KEY_OTHER:bcs_pkg::CMD_KEY_TRIP];
  assign holdoff_on = holdoff != '0;
  assign key_trip_go = key_state == bcs_pkg::BCS_KEY_CONFIRM && !key_is_close
                       && cmd[bcs_pkg::CMD_KEY_CONFIRM];
  assign key_close_go = key_state == bcs_pkg::BCS_KEY_CONFIRM && key_is_close
                        && cmd[bcs_pkg::CMD_KEY_CONFIRM];
  assign display_mode = key_state;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_state    <= bcs_pkg::BCS_KEY_DEFAULT;
      key_is_close <= 1'b0;
    end else if (cmd[bcs_pkg::CMD_KEY_EXIT]) begin
      key_state <= bcs_pkg::BCS_KEY_DEFAULT;
    end else begin
      unique case (key_state)
        bcs_pkg::BCS_KEY_DEFAULT, bcs_pkg::BCS_KEY_STATUS: begin
          if (!holdoff_on && (cmd[bcs_pkg::CMD_KEY_TRIP] || cmd[bcs_pkg::CMD_KEY_CLOSE])) begin
            key_state    <= bcs_pkg::BCS_KEY_CONFIRM;
            key_is_close <= cmd[bcs_pkg::CMD_KEY_CLOSE];
          end else if (key_state == bcs_pkg::BCS_KEY_STATUS && key_idle >= bcs_pkg::KEY_IDLE_TICKS) begin
            key_state <= bcs_pkg::BCS_KEY_DEFAULT;
          end
        end
        bcs_pkg::BCS_KEY_CONFIRM: begin
          if (key_trip_go) key_state <= bcs_pkg::BCS_KEY_STATUS;
          else if (key_close_go) key_state <= bcs_pkg::BCS_KEY_RUNNING;
          else if (cmd[bcs_pkg::CMD_KEY_CANCEL] || key_idle >= bcs_pkg::KEY_IDLE_TICKS)
            key_state <= bcs_pkg::BCS_KEY_STATUS;
        end
        bcs_pkg::BCS_KEY_RUNNING: begin
          if (seq == bcs_pkg::BCS_SEQ_IDLE && !cmd[bcs_pkg::CMD_KEY_RESTART])
            key_state <= bcs_pkg::BCS_KEY_STATUS;
        end
      endcase
    end
  end

  // idle timer restarts on any key; holdoff loads when the exit key leaves the menu
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_idle <= '0;
      holdoff  <= '0;
    end else begin
      key_idle <= key_any ? '0 : bump(key_idle, tick);
      if (cmd[bcs_pkg::CMD_KEY_EXIT] && key_state != bcs_pkg::BCS_KEY_DEFAULT)
        holdoff <= bcs_pkg::KEY_HOLDOFF_TICKS;
      else if (tick && holdoff_on)
        holdoff <= holdoff - W'(1);
    end
  end

  // request gating by command source
  logic trip_req;
  logic close_req;
  logic key_cancel;
  logic key_restart;
  assign trip_req = (src_sel[0] && (cmd[bcs_pkg::CMD_LOCAL_TRIP] || key_trip_go))
                 || (src_sel[1] && remote_trip) || (src_sel[2] && opto_trip);
  assign close_req = (src_sel[0] && (cmd[bcs_pkg::CMD_LOCAL_CLOSE] || key_close_go))
                  || (src_sel[1] && remote_close) || (src_sel[2] && opto_close);
  assign key_cancel = key_state == bcs_pkg::BCS_KEY_RUNNING && cmd[bcs_pkg::CMD_KEY_CANCEL];
  assign key_restart = key_state == bcs_pkg::BCS_KEY_RUNNING && cmd[bcs_pkg::CMD_KEY_RESTART];

  // close and trip sequencer
  bcs_pkg::bcs_seq_e next_seq;
  logic [W-1:0]      seq_cnt;
  logic              sync_en;
  logic              ready_en;
  logic              supervise_ok;
  logic              sync_fail;
  logic              ready_fail;
  logic              set_open_fail;
  logic              set_shut_fail;
  logic              manual_closed;
  assign sync_en = config_reg[bcs_pkg::CF_SYNC_EN];
  assign ready_en = config_reg[bcs_pkg::CF_READY_EN];
  assign supervise_ok = (!sync_en || sync_ok) && (!ready_en || breaker_ready);
  assign sync_fail = seq == bcs_pkg::BCS_SEQ_SUPERVISE && !supervise_ok
                     && sync_en && !sync_ok && seq_cnt >= sync_win;
  assign ready_fail = seq == bcs_pkg::BCS_SEQ_SUPERVISE && !supervise_ok
                      && ready_en && !breaker_ready && seq_cnt >= ready_win;
  assign set_open_fail = seq == bcs_pkg::BCS_SEQ_TRIP && seq_cnt >= trip_time && closed;
  assign set_shut_fail = seq == bcs_pkg::BCS_SEQ_CLOSE && !protection_trip
                         && seq_cnt >= close_time && !closed;
  assign manual_closed = seq == bcs_pkg::BCS_SEQ_CLOSE && !protection_trip
                         && seq_cnt >= close_time && closed;

  always_comb begin
    next_seq = seq;
    unique case (seq)
      bcs_pkg::BCS_SEQ_IDLE: begin
        if (!control_inhibit && pos_valid) begin
          if (trip_req && closed)
            next_seq = bcs_pkg::BCS_SEQ_TRIP;
          else if (close_req && !closed && !lockout && !protection_trip)
            next_seq = bcs_pkg::BCS_SEQ_DELAY;
        end
      end
      bcs_pkg::BCS_SEQ_DELAY: begin
        if (protection_trip || key_cancel || control_inhibit)
          next_seq = bcs_pkg::BCS_SEQ_IDLE;
        else if (!key_restart && seq_cnt >= close_delay)
          next_seq = bcs_pkg::BCS_SEQ_SUPERVISE;
      end
      bcs_pkg::BCS_SEQ_SUPERVISE: begin
        if (protection_trip || key_cancel || sync_fail || ready_fail || control_inhibit)
          next_seq = bcs_pkg::BCS_SEQ_IDLE;
        else if (key_restart)
          next_seq = bcs_pkg::BCS_SEQ_DELAY;
        else if (supervise_ok && !closed)
          next_seq = bcs_pkg::BCS_SEQ_CLOSE;
      end
      bcs_pkg::BCS_SEQ_CLOSE: begin
        if (protection_trip || seq_cnt >= close_time)
          next_seq = bcs_pkg::BCS_SEQ_IDLE;
      end
      bcs_pkg::BCS_SEQ_TRIP: begin
        if (seq_cnt >= trip_time)
          next_seq = bcs_pkg::BCS_SEQ_IDLE;
      end
      default: next_seq = bcs_pkg::BCS_SEQ_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq       <= bcs_pkg::BCS_SEQ_IDLE;
      seq_cnt   <= '0;
      trip_out  <= 1'b0;
      close_out <= 1'b0;
    end else begin
      seq       <= next_seq;
      seq_cnt   <= (next_seq != seq || key_restart) ? '0 : bump(seq_cnt, tick);
      trip_out  <= next_seq == bcs_pkg::BCS_SEQ_TRIP;
      close_out <= next_seq == bcs_pkg::BCS_SEQ_CLOSE && !protection_trip;
    end
  end

  // lockout, alarms and reclose block
  logic          closed_d;
  logic          clr_lockout;
  logic          clr_alarm;
  logic [W-1:0]  ar_cnt;
  assign clr_alarm = cmd[bcs_pkg::CMD_ALARM_CLEAR];
  assign clr_lockout = cmd[bcs_pkg::CMD_LOCKOUT_RESET]
                    || (config_reg[bcs_pkg::CF_CLR_SRC] && pos_valid && closed && !closed_d);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      closed_d      <= 1'b0;
      lockout       <= 1'b0;
      lockout_clear <= 1'b0;
    end else begin
      closed_d      <= pos_valid && closed;
      lockout       <= (lockout && !clr_lockout) || sync_fail || ready_fail;
      lockout_clear <= clr_lockout;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      open_failure_alarm <= 1'b0;
      shut_failure_alarm <= 1'b0;
      sync_alarm         <= 1'b0;
      ready_alarm        <= 1'b0;
    end else begin
      open_failure_alarm <= (open_failure_alarm && !clr_alarm) || set_open_fail;
      shut_failure_alarm <= (shut_failure_alarm && !clr_alarm) || set_shut_fail;
      sync_alarm         <= (sync_alarm && !clr_alarm) || sync_fail;
      ready_alarm        <= (ready_alarm && !clr_alarm) || ready_fail;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ar_cnt                     <= '0;
      reclose_block_after_manual <= 1'b0;
    end else begin
      if (manual_closed)
        ar_cnt <= ar_block;
      else if (tick && ar_cnt != '0)
        ar_cnt <= ar_cnt - W'(1);
      reclose_block_after_manual <= manual_closed || (ar_cnt != '0 && !(tick && ar_cnt == W'(1)));
    end
  end

  // read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        bcs_pkg::ADDR_CONFIG:      prdata <= {24'h0, config_reg};
        bcs_pkg::ADDR_TRIP_TIME:   prdata <= {8'h0, trip_time};
        bcs_pkg::ADDR_CLOSE_TIME:  prdata <= {8'h0, close_time};
        bcs_pkg::ADDR_CLOSE_DELAY: prdata <= {8'h0, close_delay};
        bcs_pkg::ADDR_READY_WIN:   prdata <= {8'h0, ready_win};
        bcs_pkg::ADDR_SYNC_WIN:    prdata <= {8'h0, sync_win};
        bcs_pkg::ADDR_AR_BLOCK:    prdata <= {8'h0, ar_block};
        bcs_pkg::ADDR_STATUS:      prdata <= {16'h0, holdoff_on, key_state, seq, close_out, trip_out,
                                              reclose_block_after_manual, ready_alarm, sync_alarm,
                                              shut_failure_alarm, open_failure_alarm, lockout,
                                              pos_valid, closed};
        default:                   prdata <= 32'h0;
      endcase
    end
  end
endmodule : bcs_sequencer

// file: rtl/bcs_pkg.sv
// constants and types for the breaker control sequencer
package bcs_pkg;
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          TICK_PERIOD_NS = 1000000;
  localparam int          TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int          CNT_W = 24;
  localparam int          AW = 8;

  localparam logic [7:0]  ADDR_CONFIG = 8'h00;
  localparam logic [7:0]  ADDR_TRIP_TIME = 8'h04;
  localparam logic [7:0]  ADDR_CLOSE_TIME = 8'h08;
  localparam logic [7:0]  ADDR_CLOSE_DELAY = 8'h0c;
  localparam logic [7:0]  ADDR_READY_WIN = 8'h10;
  localparam logic [7:0]  ADDR_SYNC_WIN = 8'h14;
  localparam logic [7:0]  ADDR_AR_BLOCK = 8'h18;
  localparam logic [7:0]  ADDR_COMMAND = 8'h1c;
  localparam logic [7:0]  ADDR_STATUS = 8'h20;

  // config fields
  localparam int          CF_POS_LSB = 0;
  localparam int          CF_SRC_LSB = 2;
  localparam int          CF_SYNC_EN = 5;
  localparam int          CF_READY_EN = 6;
  localparam int          CF_CLR_SRC = 7;
  localparam logic [7:0]  CONFIG_RESET = 8'h80;

  // command bits, write one to act
  localparam int          CMD_LOCAL_TRIP = 0;
  localparam int          CMD_LOCAL_CLOSE = 1;
  localparam int          CMD_LOCKOUT_RESET = 2;
  localparam int          CMD_ALARM_CLEAR = 3;
  localparam int          CMD_KEY_TRIP = 4;
  localparam int          CMD_KEY_CLOSE = 5;
  localparam int          CMD_KEY_CONFIRM = 6;
  localparam int          CMD_KEY_CANCEL = 7;
  localparam int          CMD_KEY_RESTART = 8;
  localparam int          CMD_KEY_EXIT = 9;
  localparam int          CMD_KEY_OTHER = 10;

  // timing resets, in ms ticks
  localparam logic [23:0] TRIP_TIME_RESET = 24'h0001f4;
  localparam logic [23:0] CLOSE_TIME_RESET = 24'h0001f4;
  localparam logic [23:0] CLOSE_DELAY_RESET = 24'h002710;
  localparam logic [23:0] READY_WIN_RESET = 24'h001388;
  localparam logic [23:0] SYNC_WIN_RESET = 24'h001388;
  localparam logic [23:0] AR_BLOCK_RESET = 24'h001388;
  localparam int          KEY_IDLE_S = 25;
  localparam int          KEY_HOLDOFF_S = 10;
  localparam logic [23:0] KEY_IDLE_TICKS = 24'(KEY_IDLE_S * 1000);
  localparam logic [23:0] KEY_HOLDOFF_TICKS = 24'(KEY_HOLDOFF_S * 1000);

  typedef enum logic [1:0] {
    BCS_POS_NONE     = 2'b00,
    BCS_POS_FOLLOWS  = 2'b01,
    BCS_POS_OPPOSES  = 2'b10,
    BCS_POS_BOTH     = 2'b11
  } bcs_pos_e;

  typedef enum logic [2:0] {
    BCS_SEQ_IDLE      = 3'b000,
    BCS_SEQ_DELAY     = 3'b001,
    BCS_SEQ_SUPERVISE = 3'b010,
    BCS_SEQ_CLOSE     = 3'b011,
    BCS_SEQ_TRIP      = 3'b100
  } bcs_seq_e;

  typedef enum logic [1:0] {
    BCS_KEY_DEFAULT = 2'b00,
    BCS_KEY_CONFIRM = 2'b01,
    BCS_KEY_RUNNING = 2'b10,
    BCS_KEY_STATUS  = 2'b11
  } bcs_key_e;
endpackage : bcs_pkg

// file: verification/bcs_monitor.sv
// port assertions for the breaker control sequencer
`timescale 1ns/1ps
module bcs_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic contact_follows_breaker,
  input wire logic contact_opposes_breaker,
  input wire logic protection_trip,
  input wire logic trip_out,
  input wire logic close_out,
  input wire logic sync_alarm,
  input wire logic ready_alarm,
  input wire logic shut_failure_alarm,
  input wire logic lockout,
  input wire logic lockout_clear,
  input wire logic reclose_block_after_manual,
  input wire logic control_inhibit
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_close_end;
    $fell(close_out);
  endsequence
  a_inhibit_blocks: assert property (
    control_inhibit && $past(control_inhibit) |-> !$rose(trip_out) && !$rose(close_out))
    else $error("coil driven while control inhibited");
  a_trip_closed: assert property (
    $rose(trip_out) |-> $past(contact_follows_breaker) || !$past(contact_opposes_breaker))
    else $error("trip issued with breaker open");
  a_close_open: assert property (
    $rose(close_out) |-> !$past(contact_follows_breaker) || $past(contact_opposes_breaker))
    else $error("close issued with breaker closed");
  a_prot_abort: assert property (
    close_out && protection_trip |=> !close_out)
    else $error("close not dropped on protection trip");
  a_coils_exclusive: assert property (
    !(trip_out && close_out))
    else $error("trip and close driven together");
  a_lockout_cause: assert property (
    $rose(lockout) |-> sync_alarm || ready_alarm)
    else $error("lockout without alarm");
  a_clear_pulse: assert property (
    lockout_clear |=> !lockout_clear)
    else $error("lockout clear longer than one cycle");
  a_close_outcome: assert property (
    s_close_end |-> reclose_block_after_manual || shut_failure_alarm || $past(protection_trip))
    else $error("close end without block or alarm");
endmodule : bcs_monitor

bind bcs_sequencer bcs_monitor u_mon (.*);

// file: verification/bcs_breaker_model.sv
// breaker model: aux contacts follow the coils after a delay
`timescale 1ns/1ps
module bcs_breaker_model #(
  parameter int RESP = 3
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic trip_out,
  input  wire logic close_out,
  input  wire logic stuck,
  input  wire logic disagree,
  output logic      contact_follows_breaker,
  output logic      contact_opposes_breaker
);
  logic closed;
  int   cnt;
  assign contact_follows_breaker = disagree | closed;
  assign contact_opposes_breaker = disagree | !closed;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      closed <= 1'b0;
      cnt    <= 0;
    end else if ((trip_out && closed) || (close_out && !closed)) begin
      cnt <= cnt + 1;
      if (cnt >= RESP && !stuck) begin
        closed <= close_out;
        cnt    <= 0;
      end
    end else begin
      cnt <= 0;
    end
  end
endmodule : bcs_breaker_model

// file: verification/bcs_sequencer_tb.sv
// testbench for the breaker control sequencer
`timescale 1ns/1ps
module bcs_sequencer_tb;
  localparam int T = 2;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        remote_trip, remote_close, opto_trip, opto_close, protection_trip, sync_ok, breaker_ready;
  logic        contact_follows_breaker, contact_opposes_breaker, trip_out, close_out, lockout, lockout_clear;
  logic        open_failure_alarm, shut_failure_alarm, sync_alarm, ready_alarm, er, stuck, disagree;
  logic        reclose_block_after_manual, control_inhibit;
  logic [1:0]  display_mode;
  int          errors, n_checks, n, k;

  bcs_sequencer #(.TICK_CYCLES(T)) u_dut (.*);
  bcs_breaker_model u_brk (.pclk(pclk), .presetn(presetn), .trip_out(trip_out), .close_out(close_out),
    .stuck(stuck), .disagree(disagree), .contact_follows_breaker(contact_follows_breaker),
    .contact_opposes_breaker(contact_opposes_breaker));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task end_sim;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (i == 100) begin
      errors++;
      end_sim();
    end
  endtask : apb

  task cmd(input int b);
    apb(1'b1, bcs_pkg::ADDR_COMMAND, 32'h1 << b);
  endtask : cmd

  function automatic logic pick(input int s);
    case (s)
      0: return trip_out;
      1: return close_out;
      default: return lockout;
    endcase
  endfunction : pick

  task wait_for(input int s);
    for (n = 0; n < 2000 && pick(s) !== 1'b1; n++) @(negedge pclk);
    if (n == 2000) begin
      errors++;
      end_sim();
    end
  endtask : wait_for

  task pulse(input int s, input int ticks);
    int len;
    wait_for(s);
    for (len = 0; len < 2000 && pick(s) === 1'b1; len++) @(negedge pclk);
    chk("pulse_len_ok", 32'(len >= (ticks - 1) * T && len <= ticks * T + 2), 32'h1);
    repeat (4) @(negedge pclk);
  endtask : pulse

  task none(input int s);
    logic seen;
    seen = 1'b0;
    repeat (40) begin
      @(negedge pclk);
      seen = seen | (pick(s) === 1'b1);
    end
    chk("no_coil", 32'(seen), 32'h0);
  endtask : none

  initial begin
    errors = 0; n_checks = 0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; remote_trip = 1'b0; remote_close = 1'b0; opto_trip = 1'b0;
    opto_close = 1'b0; protection_trip = 1'b0; sync_ok = 1'b1; breaker_ready = 1'b1; stuck = 1'b0; disagree = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, bcs_pkg::ADDR_CONFIG, 32'h0);
    chk("config_reset", rd, 32'h80);
    chk("inhibit", 32'(control_inhibit), 32'h1);
    cmd(bcs_pkg::CMD_LOCAL_CLOSE);
    none(1);
    apb(1'b0, 8'h24, 32'h0);
    chk("unmapped_err", 32'(er), 32'h1);
    for (k = 1; k < 7; k++) apb(1'b1, 8'(4 * k), (k == 3) ? 32'h3 : (k > 3) ? 32'h5 : 32'h4);
    apb(1'b1, bcs_pkg::ADDR_CONFIG, 32'h87);
    cmd(bcs_pkg::CMD_LOCAL_TRIP);
    none(0);
    cmd(bcs_pkg::CMD_LOCAL_CLOSE);
    wait_for(1);
    chk("close_delay_ok", 32'(n >= 2 * T && n <= 3 * T + 6), 32'h1);
    pulse(1, 4);
    chk("reclose_block", 32'(reclose_block_after_manual), 32'h1);
    cmd(bcs_pkg::CMD_LOCAL_CLOSE);
    none(1);
    stuck = 1'b1;
    cmd(bcs_pkg::CMD_LOCAL_TRIP);
    pulse(0, 4);
    chk("open_fail", 32'(open_failure_alarm), 32'h1);
    stuck = 1'b0;
    cmd(bcs_pkg::CMD_LOCAL_TRIP);
    pulse(0, 4);
    for (k = 0; k < 2; k++) begin
      apb(1'b1, bcs_pkg::ADDR_CONFIG, k ? 32'hc7 : 32'ha7);
      sync_ok <= 1'(k);
      breaker_ready <= 1'(!k);
      cmd(bcs_pkg::CMD_LOCAL_CLOSE);
      wait_for(2);
      chk("window_alarm", 32'(k ? ready_alarm : sync_alarm), 32'h1);
      cmd(bcs_pkg::CMD_LOCAL_CLOSE);
      none(1);
      cmd(bcs_pkg::CMD_LOCKOUT_RESET);
      @(negedge pclk);
      chk("lockout_cleared", 32'(lockout), 32'h0);
      chk("lockout_clear", 32'(lockout_clear), 32'h1);
    end
    sync_ok <= 1'b1;
    breaker_ready <= 1'b1;
    apb(1'b1, bcs_pkg::ADDR_CONFIG, 32'h87);
    cmd(bcs_pkg::CMD_LOCAL_CLOSE);
    wait_for(1);
    @(posedge pclk);
    protection_trip <= 1'b1;
    repeat (2) @(negedge pclk);
    chk("close_aborted", 32'(close_out), 32'h0);
    @(posedge pclk);
    protection_trip <= 1'b0;
    remote_close <= 1'b1;
    none(1);
    @(posedge pclk);
    remote_close <= 1'b0;
    apb(1'b1, bcs_pkg::ADDR_CONFIG, 32'h8b);
    disagree <= 1'b1;
    remote_close <= 1'b1;
    none(1);
    disagree = 1'b0;
    pulse(1, 4);
    @(posedge pclk);
    remote_close <= 1'b0;
    apb(1'b1, bcs_pkg::ADDR_CONFIG, 32'h87);
    cmd(bcs_pkg::CMD_KEY_TRIP);
    @(negedge pclk);
    chk("prompt", 32'(display_mode), 32'h1);
    none(0);
    cmd(bcs_pkg::CMD_KEY_CONFIRM);
    pulse(0, 4);
    for (n = 0; n < 60000 && display_mode !== 2'd0; n++) @(negedge pclk);
    chk("status_idle_ok", 32'(n >= 24990 * T && n < 60000), 32'h1);
    cmd(bcs_pkg::CMD_KEY_CLOSE);
    cmd(bcs_pkg::CMD_KEY_CONFIRM);
    @(negedge pclk);
    chk("timing_bar", 32'(display_mode), 32'h2);
    cmd(bcs_pkg::CMD_KEY_CANCEL);
    none(1);
    chk("cancel_status", 32'(display_mode), 32'h3);
    cmd(bcs_pkg::CMD_KEY_TRIP);
    cmd(bcs_pkg::CMD_KEY_EXIT);
    cmd(bcs_pkg::CMD_KEY_TRIP);
    @(negedge pclk);
    chk("holdoff", 32'(display_mode), 32'h0);
    apb(1'b0, bcs_pkg::ADDR_STATUS, 32'h0);
    chk("status", rd, 32'h0000806a);
    cmd(bcs_pkg::CMD_ALARM_CLEAR);
    apb(1'b0, bcs_pkg::ADDR_STATUS, 32'h0);
    chk("status_clear", rd, 32'h00008002);
    end_sim();
  end
endmodule : bcs_sequencer_tb
